// ===== hw/scs_pkg.sv
// Purpose: Constants for the system clock select and setup block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Registers are 8 bits wide in the low byte of each word
package scs_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [5:0] ADDR_WPROT   = 6'h00;
  localparam logic [5:0] ADDR_OSCCTL  = 6'h04;
  localparam logic [5:0] ADDR_EXTPIN  = 6'h08;
  localparam logic [5:0] ADDR_SYSCTL  = 6'h0c;
  localparam logic [5:0] ADDR_SYSDIV  = 6'h10;
  localparam logic [5:0] ADDR_STOPCTL = 6'h14;
  localparam logic [5:0] ADDR_MSTBY   = 6'h18;
  localparam logic [5:0] ADDR_STATUS  = 6'h1c;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int WE_BIT      = 0;
  localparam int LOSTOP_BIT  = 1;
  localparam int HSSEL_BIT   = 6;
  localparam int BASESEL_BIT = 7;
  localparam int TMRSB_BIT   = 1;
  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0] RST_WPROT   = 8'h00;
  localparam logic [7:0] RST_OSCCTL  = 8'h00;
  localparam logic [7:0] RST_EXTPIN  = 8'h00;
  localparam logic [7:0] RST_SYSCTL  = 8'h40;
  localparam logic [7:0] RST_SYSDIV  = 8'h00;
  localparam logic [7:0] RST_STOPCTL = 8'h00;
  localparam logic [7:0] RST_MSTBY   = 8'h02;
  localparam logic [1:0] PIN_EXT_XTAL = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/scs_top.sv
// Purpose: Clock generation control registers with write protect
// Assumes: clk 10 MHz; clock sources arrive as enables sampled on clk
// Notes:   Divided clocks are produced as one-cycle enable strobes
`timescale 1ns/1ns
`default_nettype none
module scs_top
  import scs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // AXI4-Lite write
  input  wire logic [5:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // AXI4-Lite read
  input  wire logic [5:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Clock source ticks from oscillators and pads
  input  wire logic        hs_osc_tick,
  input  wire logic        low_speed_osc_tick,
  input  wire logic        external_clock_input,
  // Clock control outputs
  output logic             low_speed_osc_run,
  output logic             ext_pins_clock_mode,
  output logic             crystal_drive_output,
  output logic             high_speed_clock,
  output logic             system_base_clock,
  output logic             system_clock,
  output logic             cpu_clock,
  output logic             timer_clock,
  output logic             timer_module_standby
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] clock_write_protect;
  logic [7:0] onchip_oscillator_control;
  logic [7:0] external_clock_pin_control;
  logic [7:0] system_clock_control;
  logic [7:0] system_clock_divider;
  logic [7:0] clock_stop_control;
  logic [7:0] module_standby_control;
  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  logic       aw_held;
  logic       w_held;
  logic [5:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_lane0;
  wire        aw_take = s_awvalid && s_awready;
  wire        w_take  = s_wvalid && s_wready;
  wire        wr_fire = aw_held && w_held && !s_bvalid;
  wire        clock_reg_write_enable = clock_write_protect[WE_BIT];
  wire        hit_wprot = aw_addr == ADDR_WPROT;
  wire        hit_prot  = aw_addr == ADDR_OSCCTL || aw_addr == ADDR_EXTPIN ||
                          aw_addr == ADDR_SYSCTL || aw_addr == ADDR_SYSDIV ||
                          aw_addr == ADDR_STOPCTL || aw_addr == ADDR_MSTBY;
  wire        hit_rd    = aw_addr == ADDR_STATUS;
  // A blocked write still answers OKAY, like a silently ignored store
  wire        wr_ok     = wr_fire && w_lane0;
  wire        wr_prot   = wr_ok && hit_prot && clock_reg_write_enable;
  wire        wr_pr     = wr_ok && hit_wprot;
  assign s_awready = !aw_held;
  assign s_wready  = !w_held;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 6'h00;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_awaddr[5:2], 2'b00};
      end
      if (w_take) begin
        w_held  <= 1'b1;
        w_byte  <= s_wdata[7:0];
        w_lane0 <= s_wstrb[0];
      end
      if (wr_fire) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (hit_prot || hit_wprot || hit_rd) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // Register storage
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clock_write_protect        <= RST_WPROT;
      onchip_oscillator_control  <= RST_OSCCTL;
      external_clock_pin_control <= RST_EXTPIN;
      system_clock_control       <= RST_SYSCTL;
      system_clock_divider       <= RST_SYSDIV;
      clock_stop_control         <= RST_STOPCTL;
      module_standby_control     <= RST_MSTBY;
    end else if (clk_en) begin
      if (wr_pr) begin
        clock_write_protect <= w_byte;
      end
      if (wr_prot) begin
        case (aw_addr)
          ADDR_OSCCTL:  onchip_oscillator_control  <= w_byte;
          ADDR_EXTPIN:  external_clock_pin_control <= w_byte;
          ADDR_SYSCTL:  system_clock_control       <= w_byte;
          ADDR_SYSDIV:  system_clock_divider       <= w_byte;
          ADDR_STOPCTL: clock_stop_control         <= w_byte;
          ADDR_MSTBY:   module_standby_control     <= w_byte;
          default:      clock_write_protect        <= clock_write_protect;
        endcase
      end
    end
  end
  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_araddr[5:2])
      ADDR_WPROT[5:2]:   rd_mux = clock_write_protect;
      ADDR_OSCCTL[5:2]:  rd_mux = onchip_oscillator_control;
      ADDR_EXTPIN[5:2]:  rd_mux = external_clock_pin_control;
      ADDR_SYSCTL[5:2]:  rd_mux = system_clock_control;
      ADDR_SYSDIV[5:2]:  rd_mux = system_clock_divider;
      ADDR_STOPCTL[5:2]: rd_mux = clock_stop_control;
      ADDR_MSTBY[5:2]:   rd_mux = module_standby_control;
      ADDR_STATUS[5:2]:  rd_mux = status;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign s_arready = !s_rvalid;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= {24'h00_0000, rd_mux};
        s_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************************************
  // Clock selection and dividers
  // ****************************************************************
  // External input is a pin: two flops before use
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic [7:0] sys_cnt;
  logic [6:0] cpu_cnt;
  wire [1:0] ext_clock_pin_sel = external_clock_pin_control[1:0];
  wire       high_speed_source_sel = system_clock_control[HSSEL_BIT];
  wire       base_clock_source_sel = clock_stop_control[BASESEL_BIT];
  wire [2:0] cpu_div_sel = system_clock_control[2:0];
  wire       low_speed_osc_stop = onchip_oscillator_control[LOSTOP_BIT];
  wire       pins_on  = ext_clock_pin_sel == PIN_EXT_XTAL;
  wire       ext_tick = pins_on && ext_s2 && !ext_s3;
  wire       hs_tick  = high_speed_source_sel ? hs_osc_tick : ext_tick;
  wire       lo_tick  = low_speed_osc_tick && !low_speed_osc_stop;
  wire       base_tick = base_clock_source_sel ? hs_tick : lo_tick;
  wire       sys_tick = base_tick && (sys_cnt == system_clock_divider);
  // CPU divide by 2^k; 000 means every system tick
  wire [6:0] cpu_mask = 7'(({7'h00, 1'b1} << cpu_div_sel) - 8'h01);
  wire       cpu_tick = sys_tick && ((cpu_cnt & cpu_mask) == 7'h00);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_s1  <= 1'b0;
      ext_s2  <= 1'b0;
      ext_s3  <= 1'b0;
      sys_cnt <= 8'h00;
      cpu_cnt <= 7'h00;
    end else if (clk_en) begin
      ext_s1 <= external_clock_input;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (base_tick) begin
        sys_cnt <= (sys_cnt >= system_clock_divider) ? 8'h00 : sys_cnt + 8'h01;
      end
      if (sys_tick) begin
        cpu_cnt <= cpu_cnt + 7'h01;
      end
    end
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign timer_module_standby = module_standby_control[TMRSB_BIT];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_speed_osc_run    <= 1'b0;
      ext_pins_clock_mode  <= 1'b0;
      crystal_drive_output <= 1'b0;
      high_speed_clock     <= 1'b0;
      system_base_clock    <= 1'b0;
      system_clock         <= 1'b0;
      cpu_clock            <= 1'b0;
      timer_clock          <= 1'b0;
    end else if (clk_en) begin
      low_speed_osc_run    <= !low_speed_osc_stop;
      ext_pins_clock_mode  <= pins_on;
      crystal_drive_output <= pins_on && !ext_s2;
      high_speed_clock     <= hs_tick;
      system_base_clock    <= base_tick;
      system_clock         <= sys_tick;
      cpu_clock            <= cpu_tick;
      timer_clock          <= sys_tick && !timer_module_standby;
    end
  end
  // ****************************************************************
  // Status
  // ****************************************************************
  // Software polls this before switching sources
  assign status = {4'h0, pins_on, base_clock_source_sel, high_speed_source_sel,
                   !low_speed_osc_stop};
endmodule
`default_nettype wire

// ===== tb/scs_properties.sv
// Purpose: Port-level checks for the clock select block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Tick relations allow up to two cycles of delay, five from the external pin
`timescale 1ns/1ns
`default_nettype none
module scs_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Bus answers
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [31:0] s_rdata,
  // Sources and clock outputs
  input wire logic        hs_osc_tick,
  input wire logic        low_speed_osc_tick,
  input wire logic        external_clock_input,
  input wire logic        high_speed_clock,
  input wire logic        system_base_clock,
  input wire logic        system_clock,
  input wire logic        cpu_clock,
  input wire logic        timer_clock,
  input wire logic        timer_module_standby,
  input wire logic        ext_pins_clock_mode,
  input wire logic        crystal_drive_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_timer_gated: assert property (timer_module_standby && $past(timer_module_standby) |-> !timer_clock)
    else $error("timer clock ticks in standby");
  chk_bresp_held: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  chk_rdata_held: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  chk_crystal_idle: assert property (!ext_pins_clock_mode |-> !crystal_drive_output)
    else $error("crystal driven without pin mode");
  chk_hs_cause: assert property (high_speed_clock |-> $past(hs_osc_tick)
    || $past(external_clock_input, 2) || $past(external_clock_input, 3)
    || $past(external_clock_input, 4) || $past(external_clock_input, 5))
    else $error("high-speed tick without source");
  chk_base_cause: assert property (system_base_clock |-> high_speed_clock
    || $past(high_speed_clock) || $past(low_speed_osc_tick) || $past(low_speed_osc_tick, 2))
    else $error("base tick without source");
  chk_sys_cause: assert property (system_clock |-> system_base_clock || $past(system_base_clock))
    else $error("system tick without base tick");
  chk_cpu_cause: assert property (cpu_clock |-> system_clock || $past(system_clock))
    else $error("cpu tick without system tick");
endmodule
bind scs_top scs_properties chk_i (.clk, .sys_rst, .s_bvalid, .s_bready, .s_bresp, .s_rvalid,
  .s_rready, .s_rdata, .hs_osc_tick, .low_speed_osc_tick, .external_clock_input,
  .high_speed_clock, .system_base_clock, .system_clock, .cpu_clock, .timer_clock,
  .timer_module_standby, .ext_pins_clock_mode, .crystal_drive_output);
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Register-level test of the clock select block
// Assumes: AXI4-Lite master; sources are ticks on clk
// Notes:   Tick windows span whole source periods, so counts are exact
`timescale 1ns/1ns
`default_nettype none
module tb
  import scs_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 0, sys_rst = 1, clk_en = 1;
  logic [5:0]  s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata, v, cyc = 0;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic        hs_osc_tick = 0, low_speed_osc_tick = 0, external_clock_input = 0;
  logic        low_speed_osc_run, ext_pins_clock_mode, crystal_drive_output, high_speed_clock;
  logic        system_base_clock, system_clock, cpu_clock, timer_clock, timer_module_standby;
  logic [31:0] cnt [5], d [5];
  logic [7:0]  rv [7] = '{RST_WPROT, RST_OSCCTL, RST_EXTPIN, RST_SYSCTL, RST_SYSDIV,
                          RST_STOPCTL, RST_MSTBY};
  wire  [4:0]  tk = {timer_clock, cpu_clock, system_clock, system_base_clock, high_speed_clock};
  int          n_errors = 0, compares = 0;
  scs_top dut (.clk, .sys_rst, .clk_en, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .hs_osc_tick, .low_speed_osc_tick,
    .external_clock_input, .low_speed_osc_run, .ext_pins_clock_mode, .crystal_drive_output,
    .high_speed_clock, .system_base_clock, .system_clock, .cpu_clock, .timer_clock,
    .timer_module_standby);
  // ****************************************************************
  // Clock, sources and tick counters
  // ****************************************************************
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hs_osc_tick <= !cyc[0];
    low_speed_osc_tick <= cyc[3:0] == 4'h0;
    external_clock_input <= cyc[2];
    foreach (cnt[i]) cnt[i] <= cnt[i] + 32'(tk[i]);
    if (cyc == 32'd6000) begin
      n_errors++;
      complete_run();
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] dv, input logic [1:0] er);
    logic aw, w;
    aw = 1;
    w = 1;
    s_awaddr <= a;
    s_wdata <= {24'h0, dv};
    s_awvalid <= 1;
    s_wvalid <= 1;
    forever begin
      @(posedge clk);
      if (aw && s_awready) begin aw = 0; s_awvalid <= 0; end
      if (w && s_wready) begin w = 0; s_wvalid <= 0; end
      if (s_bvalid && s_bready) break;
      if (s_bvalid) s_bready <= 1;
    end
    chk(32'(s_bresp), 32'(er));
    s_bready <= 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar;
    ar = 1;
    s_araddr <= a;
    s_arvalid <= 1;
    forever begin
      @(posedge clk);
      if (ar && s_arready) begin ar = 0; s_arvalid <= 0; end
      if (s_rvalid && s_rready) break;
      if (s_rvalid) s_rready <= 1;
    end
    chk(s_rdata, e);
    chk(32'(s_rresp), 32'(er));
    s_rready <= 0;
  endtask
  // Settle first, since outputs trail a write by a few register stages
  task automatic meas(input int n);
    logic [31:0] s [5];
    repeat (8) @(posedge clk);
    s = cnt;
    repeat (n) @(posedge clk);
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask
  task automatic complete_run();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    foreach (cnt[i]) cnt[i] = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    for (int i = 1; i < 7; i++) wr(6'(4 * i), ~rv[i], RESP_OKAY);
    foreach (rv[i]) rd(6'(4 * i), {24'h0, rv[i]}, RESP_OKAY);
    rd(ADDR_STATUS, 32'h3, RESP_OKAY);
    wr(6'h20, 8'hff, RESP_SLVERR);
    rd(6'h20, 32'h0, RESP_SLVERR);
    meas(64);
    chk(32'(low_speed_osc_run), 1);
    chk(32'(timer_module_standby), 1);
    chk(32'(ext_pins_clock_mode), 0);
    chk(32'(crystal_drive_output), 0);
    chk(d[0], 32);
    chk(d[1], 4);
    chk(d[2], 4);
    chk(d[3], 4);
    chk(d[4], 0);
    wr(ADDR_WPROT, 8'h01, RESP_OKAY);
    wr(ADDR_OSCCTL, 8'h02, RESP_OKAY);
    meas(64);
    chk(32'(low_speed_osc_run), 0);
    chk(d[1], 0);
    wr(ADDR_OSCCTL, 8'h00, RESP_OKAY);
    wr(ADDR_EXTPIN, 8'h03, RESP_OKAY);
    meas(64);
    chk(32'(ext_pins_clock_mode), 1);
    chk(32'(low_speed_osc_run), 1);
    wr(ADDR_SYSCTL, 8'h00, RESP_OKAY);
    meas(64);
    chk(d[0], 8);
    wr(ADDR_SYSDIV, 8'h02, RESP_OKAY);
    wr(ADDR_STOPCTL, 8'h80, RESP_OKAY);
    wr(ADDR_MSTBY, 8'h00, RESP_OKAY);
    meas(192);
    chk(d[1], 24);
    chk(d[2], 8);
    chk(d[3], 8);
    chk(32'(timer_module_standby), 0);
    chk(32'(d[4] != 0), 1);
    wr(ADDR_SYSDIV, 8'h00, RESP_OKAY);
    wr(ADDR_SYSCTL, 8'h01, RESP_OKAY);
    meas(192);
    chk(d[2], 24);
    chk(d[3], 12);
    wr(ADDR_WPROT, 8'h00, RESP_OKAY);
    wr(ADDR_STOPCTL, 8'h00, RESP_OKAY);
    rd(ADDR_STOPCTL, 32'h80, RESP_OKAY);
    rd(ADDR_STATUS, 32'hd, RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
